// ===== flash_cmd_pkg.sv
// Constants, command codes and state encoding for the flash command controller
// Summary of operation
// - Resume code restarts suspended programming; status polled
// - Extra resumes ignored; new suspend still accepted
// - Enhanced mode only in x16; only enhanced commands
// - Two-write exit returns to array read
// - 256-word buffer shares address bits 23..8
// - Wrong block, page, count or order aborts
// - Abort sets abort flag, toggles, clears error
// - Busy status shows abort, error, toggle, polling
// - Six writes start chip erase of unprotected blocks
// - Protected blocks skipped; all protected ends quickly
// - Chip erase ignores every command, shows status
// - Failed erase holds status until reset command
// - Bypass chip erase takes two writes
// - Added blocks restart the selection timeout
// - Protected blocks in list silently skipped
// - Block erase takes only suspend, reset, more blocks during timeout
// - Bypass block erase takes two writes, repeatable
// - Suspend halts erase, ends timeout at once
// - Suspended: other blocks usable, bad programs ignored
// - Erase resume only in array read mode
package flash_cmd_pkg;
	localparam int CLK_MHZ = 10;
	// All-protected erase finishes within this time
	localparam int PROT_TIME_US = 100;
	localparam int PROT_CYC = PROT_TIME_US * CLK_MHZ;
	localparam int BLK_TMO_CYC_DEF = 500;
	localparam int ERASE_CYC_DEF = 10000;
	localparam int PROG_CYC_DEF = 160;
	localparam int EBP_CYC_DEF = 8000;
	localparam int TMR_W = 24;
	localparam int EBP_WORDS = 256;
	// Unlock addresses per bus width
	localparam logic [11:0] UNL1_X16 = 12'h555;
	localparam logic [11:0] UNL2_X16 = 12'h2AA;
	localparam logic [11:0] UNL1_X8 = 12'hAAA;
	localparam logic [11:0] UNL2_X8 = 12'h555;
	// Command data codes
	localparam logic [7:0] CMD_UNL1 = 8'hAA;
	localparam logic [7:0] CMD_UNL2 = 8'h55;
	localparam logic [7:0] CMD_ERS_SETUP = 8'h80;
	localparam logic [7:0] CMD_CHIP = 8'h10;
	localparam logic [7:0] CMD_BLK = 8'h30;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [7:0] CMD_SUSP = 8'hB0;
	localparam logic [7:0] CMD_RESET = 8'hF0;
	localparam logic [7:0] CMD_PROG = 8'hA0;
	localparam logic [7:0] CMD_BYP = 8'h20;
	localparam logic [7:0] CMD_ASEL = 8'h90;
	localparam logic [7:0] CMD_EXIT1 = 8'h90;
	localparam logic [7:0] CMD_EXIT2 = 8'h00;
	localparam logic [7:0] CMD_EBP_ENTER = 8'h38;
	localparam logic [7:0] CMD_EBP_SETUP = 8'h33;
	localparam logic [7:0] CMD_CONFIRM = 8'h29;
	// Status bit positions
	localparam int ST_POLL = 7;
	localparam int ST_TOG = 6;
	localparam int ST_ERR = 5;
	localparam int ST_ABRT = 1;
	typedef enum logic [4:0] {
		S_READ = 5'h00,
		S_U1 = 5'h01,
		S_U2 = 5'h03,
		S_E1 = 5'h02,
		S_E2 = 5'h06,
		S_E3 = 5'h07,
		S_BTMO = 5'h05,
		S_BERS = 5'h04,
		S_PROG = 5'h0C,
		S_PSUSP = 5'h0D,
		S_CERS = 5'h0F,
		S_FAIL = 5'h0E,
		S_EBP = 5'h0A,
		S_EBLD = 5'h0B,
		S_EBPG = 5'h09,
		S_EBAB = 5'h08,
		S_BYP80 = 5'h18,
		S_PDATA = 5'h19
	} st_t;
endpackage

// ===== op_timer.sv
// Loadable down-counter pacing the internal program/erase operations
`timescale 1ns/100ps
module op_timer
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [flash_cmd_pkg::TMR_W-1:0] val,
	input wire logic run,
	output logic done
);
	import flash_cmd_pkg::*;
	typedef struct packed {
		logic [TMR_W-1:0] cnt;
		logic done;
	} tmr_t;
	tmr_t s_q, s_d;

	// Count holds while run is low, so a suspended erase keeps its place
	always_comb
	begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (load)
			s_d.cnt = val;
		else if (run && s_q.cnt != '0)
		begin
			s_d.cnt = s_q.cnt - 1'b1;
			s_d.done = (s_q.cnt == {{(TMR_W-1){1'b0}}, 1'b1});
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign done = s_q.done;
endmodule // op_timer

// ===== ebuf_track.sv
// Load-order and page checker for the 256-word enhanced buffer
`timescale 1ns/100ps
module ebuf_track
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [7:0] blk,
	input wire logic load,
	input wire logic [23:0] addr,
	output logic full,
	output logic bad
);
	import flash_cmd_pkg::*;
	typedef struct packed {
		logic [8:0] cnt;
		logic [7:0] blk;
		logic [7:0] page;
	} trk_t;
	trk_t s_q, s_d;

	// First load fixes the page; later loads must match it and the count
	always_comb
	begin
		bad = (addr[23:16] != s_q.blk) || (addr[7:0] != s_q.cnt[7:0]) || full;
		if (s_q.cnt != '0 && addr[15:8] != s_q.page)
			bad = 1'b1;
	end

	always_comb
	begin
		s_d = s_q;
		if (start)
		begin
			s_d.cnt = '0;
			s_d.blk = blk;
		end
		else if (load)
		begin
			s_d.cnt = s_q.cnt + 1'b1;
			if (s_q.cnt == '0)
				s_d.page = addr[15:8];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign full = (s_q.cnt == 9'(EBP_WORDS));
endmodule // ebuf_track

// ===== flash_cmd_ctrl.sv
// Command decoder and sequencer for program, buffered program and erase
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/100ps
module flash_cmd_ctrl
#(
	parameter int BLK_TMO_CYC = flash_cmd_pkg::BLK_TMO_CYC_DEF,
	parameter int ERASE_CYC = flash_cmd_pkg::ERASE_CYC_DEF,
	parameter int EBP_CYC = flash_cmd_pkg::EBP_CYC_DEF
)
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic word_mode,
	input wire logic [23:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [15:0] rdata,
	input wire logic [15:0] array_rdata,
	input wire logic blk_prot,
	input wire logic blk_susp,
	input wire logic all_prot,
	input wire logic op_fail,
	output logic prog_stb,
	output logic [23:0] op_addr,
	output logic [15:0] op_data,
	output logic buf_stb,
	output logic ers_sel_stb,
	output logic ers_go_stb,
	output logic chip_ers_stb,
	output logic ers_suspended,
	output logic prog_suspended,
	output logic bypass_mode,
	output logic asel_mode,
	output logic ebp_mode
);
	import flash_cmd_pkg::*;

	typedef struct packed {
		st_t st;
		logic wm1;
		logic wm2;
		logic byp;
		logic esusp;
		logic etmo_susp;
		logic asel;
		logic x1;
		logic tog;
		logic dpoll;
		logic err;
		logic abrt;
		logic any_unprot;
		logic [15:0] rdata;
		logic prog_stb;
		logic buf_stb;
		logic sel_stb;
		logic go_stb;
		logic chip_stb;
		logic [23:0] addr;
		logic [15:0] data;
	} ctl_t;
	ctl_t s_q, s_d;

	logic [1:0] rs_q;
	logic rst_n;
	logic te_load, te_run, te_done;
	logic [TMR_W-1:0] te_val;
	logic tp_load, tp_run, tp_done;
	logic [TMR_W-1:0] tp_val;
	logic tr_start, tr_load, tr_full, tr_bad;
	logic busy, stat_sel;
	logic [7:0] d8;
	logic [7:0] stat;

	// Unlock address match; which pair depends on the bus width
	function automatic logic is_unl(input logic [23:0] a, input logic second,
		input logic x16);
		logic [11:0] ref_a;
		begin
			if (x16)
				ref_a = second ? UNL2_X16 : UNL1_X16;
			else
				ref_a = second ? UNL2_X8 : UNL1_X8;
			if (x16)
				is_unl = (a[10:0] == ref_a[10:0]);
			else
				is_unl = (a[11:0] == ref_a);
		end
	endfunction

	// Reset release through two flops so no flop leaves reset mid-edge
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			rs_q <= 2'b00;
		else
			rs_q <= {rs_q[0], 1'b1};
	end
	assign rst_n = rs_q[1];

	op_timer u_erase_tmr
	(
		.core_clk(core_clk),
		.rst_n(rst_n),
		.load(te_load),
		.val(te_val),
		.run(te_run),
		.done(te_done)
	);

	op_timer u_prog_tmr
	(
		.core_clk(core_clk),
		.rst_n(rst_n),
		.load(tp_load),
		.val(tp_val),
		.run(tp_run),
		.done(tp_done)
	);

	ebuf_track u_track
	(
		.core_clk(core_clk),
		.rst_n(rst_n),
		.start(tr_start),
		.blk(addr[23:16]),
		.load(tr_load),
		.addr(addr),
		.full(tr_full),
		.bad(tr_bad)
	);

	// Status decode; erase timer only runs while selecting or erasing
	assign d8 = wdata[7:0];
	assign busy = (s_q.st == S_BTMO) || (s_q.st == S_BERS) || (s_q.st == S_CERS)
		|| (s_q.st == S_PROG) || (s_q.st == S_EBPG) || (s_q.st == S_EBAB);
	assign stat_sel = busy || (s_q.st == S_FAIL)
		|| (s_q.esusp && blk_susp && s_q.st == S_READ);
	assign te_run = (s_q.st == S_BTMO) || (s_q.st == S_BERS) || (s_q.st == S_CERS);
	assign tp_run = (s_q.st == S_PROG) || (s_q.st == S_EBPG);

	always_comb
	begin
		stat = 8'h00;
		stat[ST_POLL] = s_q.dpoll;
		stat[ST_TOG] = s_q.tog;
		stat[ST_ERR] = s_q.err;
		stat[ST_ABRT] = s_q.abrt;
	end

	// Main sequencer: one write is decoded per cycle, reads never stall
	always_comb
	begin
		s_d = s_q;
		s_d.wm1 = word_mode;
		s_d.wm2 = s_q.wm1;
		s_d.prog_stb = 1'b0;
		s_d.buf_stb = 1'b0;
		s_d.sel_stb = 1'b0;
		s_d.go_stb = 1'b0;
		s_d.chip_stb = 1'b0;
		te_load = 1'b0;
		te_val = TMR_W'(BLK_TMO_CYC);
		tp_load = 1'b0;
		tp_val = TMR_W'(PROG_CYC_DEF);
		tr_start = 1'b0;
		tr_load = 1'b0;
		if (rd_stb)
		begin
			if (stat_sel)
				s_d.rdata = {8'h00, stat};
			else
				s_d.rdata = array_rdata;
			if (busy)
				s_d.tog = ~s_q.tog;
		end
		unique case (s_q.st)
			S_READ:
				if (wr_stb)
				begin
					if (s_q.x1)
					begin
						s_d.x1 = 1'b0;
						if (d8 == CMD_EXIT2)
							s_d.byp = 1'b0;
					end
					else if (d8 == CMD_RESET)
						s_d.asel = 1'b0;
					else if (d8 == CMD_RESUME && s_q.esusp)
					begin
						// Resume only from array read, not auto-select
						if (!s_q.asel)
						begin
							s_d.esusp = 1'b0;
							s_d.st = S_BERS;
							s_d.dpoll = 1'b0;
							if (s_q.etmo_susp)
							begin
								te_load = 1'b1;
								te_val = s_q.any_unprot ? TMR_W'(ERASE_CYC) : TMR_W'(PROT_CYC);
								s_d.go_stb = 1'b1;
							end
						end
					end
					else if (s_q.byp && d8 == CMD_PROG)
						s_d.st = S_PDATA;
					else if (s_q.byp && d8 == CMD_ERS_SETUP && !s_q.esusp)
						s_d.st = S_BYP80;
					else if (s_q.byp && d8 == CMD_EXIT1)
						s_d.x1 = 1'b1;
					else if (!s_q.byp && d8 == CMD_UNL1 && is_unl(addr, 1'b0, s_q.wm2))
						s_d.st = S_U1;
				end
			S_U1:
				if (wr_stb)
					s_d.st = (d8 == CMD_UNL2 && is_unl(addr, 1'b1, s_q.wm2)) ? S_U2 : S_READ;
			S_U2:
				if (wr_stb)
				begin
					s_d.st = S_READ;
					if (is_unl(addr, 1'b0, s_q.wm2))
					begin
						if (d8 == CMD_ERS_SETUP && !s_q.esusp)
							s_d.st = S_E1;
						else if (d8 == CMD_PROG)
							s_d.st = S_PDATA;
						else if (d8 == CMD_BYP)
							s_d.byp = 1'b1;
						else if (d8 == CMD_ASEL)
							s_d.asel = 1'b1;
						else if (d8 == CMD_EBP_ENTER && s_q.wm2 && !s_q.esusp)
							s_d.st = S_EBP;
					end
				end
			S_E1:
				if (wr_stb)
					s_d.st = (d8 == CMD_UNL1 && is_unl(addr, 1'b0, s_q.wm2)) ? S_E2 : S_READ;
			S_E2:
				if (wr_stb)
					s_d.st = (d8 == CMD_UNL2 && is_unl(addr, 1'b1, s_q.wm2)) ? S_E3 : S_READ;
			S_E3, S_BYP80:
				if (wr_stb)
				begin
					s_d.st = S_READ;
					s_d.err = 1'b0;
					s_d.dpoll = 1'b0;
					if (d8 == CMD_CHIP && (s_q.st == S_BYP80 || is_unl(addr, 1'b0, s_q.wm2)))
					begin
						// All-protected chip ends in the short window, data kept
						s_d.st = S_CERS;
						s_d.chip_stb = 1'b1;
						te_load = 1'b1;
						te_val = all_prot ? TMR_W'(PROT_CYC) : TMR_W'(ERASE_CYC);
					end
					else if (d8 == CMD_BLK)
					begin
						s_d.st = S_BTMO;
						s_d.addr = addr;
						s_d.sel_stb = !blk_prot;
						s_d.any_unprot = !blk_prot;
						te_load = 1'b1;
					end
				end
			S_BTMO:
				// Expiry wins over a late add: the controller has then started
				if (te_done)
				begin
					s_d.st = S_BERS;
					s_d.go_stb = 1'b1;
					te_load = 1'b1;
					te_val = s_q.any_unprot ? TMR_W'(ERASE_CYC) : TMR_W'(PROT_CYC);
				end
				else if (wr_stb)
				begin
					if (d8 == CMD_SUSP)
					begin
						s_d.st = S_READ;
						s_d.esusp = 1'b1;
						s_d.etmo_susp = 1'b1;
					end
					else if (d8 == CMD_RESET)
						s_d.st = S_READ;
					else if (d8 == CMD_BLK)
					begin
						s_d.addr = addr;
						s_d.sel_stb = !blk_prot;
						s_d.any_unprot = s_q.any_unprot | !blk_prot;
						te_load = 1'b1;
					end
				end
			S_BERS:
				if (te_done)
				begin
					s_d.st = op_fail ? S_FAIL : S_READ;
					s_d.err = op_fail;
				end
				else if (wr_stb && d8 == CMD_SUSP)
				begin
					s_d.st = S_READ;
					s_d.esusp = 1'b1;
					s_d.etmo_susp = 1'b0;
				end
			S_CERS:
				if (te_done)
				begin
					s_d.st = op_fail ? S_FAIL : S_READ;
					s_d.err = op_fail;
				end
			S_PDATA:
				if (wr_stb)
				begin
					s_d.st = S_READ;
					if (!(s_q.esusp && (blk_prot || blk_susp)))
					begin
						s_d.st = S_PROG;
						s_d.prog_stb = 1'b1;
						s_d.addr = addr;
						s_d.data = wdata;
						s_d.dpoll = ~wdata[7];
						s_d.err = 1'b0;
						tp_load = 1'b1;
					end
				end
			S_PROG:
				// Further resume codes fall through here unheeded
				if (tp_done)
				begin
					s_d.st = op_fail ? S_FAIL : S_READ;
					s_d.err = op_fail;
					s_d.dpoll = s_q.data[7];
				end
				else if (wr_stb && d8 == CMD_SUSP)
					s_d.st = S_PSUSP;
			S_PSUSP:
				if (wr_stb && d8 == CMD_RESUME)
					s_d.st = S_PROG;
			S_EBP:
				if (wr_stb)
				begin
					if (s_q.x1)
					begin
						s_d.x1 = 1'b0;
						if (d8 == CMD_EXIT2)
							s_d.st = S_READ;
					end
					else if (d8 == CMD_EXIT1)
						s_d.x1 = 1'b1;
					else if (d8 == CMD_EBP_SETUP)
					begin
						s_d.st = S_EBLD;
						s_d.abrt = 1'b0;
						s_d.err = 1'b0;
						tr_start = 1'b1;
					end
				end
			S_EBLD:
				if (wr_stb)
				begin
					if (tr_full && d8 == CMD_CONFIRM)
					begin
						s_d.st = S_EBPG;
						s_d.dpoll = ~s_q.data[7];
						tp_load = 1'b1;
						tp_val = TMR_W'(EBP_CYC);
					end
					else if (tr_full || tr_bad)
					begin
						s_d.st = S_EBAB;
						s_d.abrt = 1'b1;
						s_d.err = 1'b0;
						s_d.dpoll = ~s_q.data[7];
					end
					else
					begin
						tr_load = 1'b1;
						s_d.buf_stb = 1'b1;
						s_d.addr = addr;
						s_d.data = wdata;
					end
				end
			S_EBPG:
				if (tp_done)
				begin
					s_d.st = op_fail ? S_FAIL : S_EBP;
					s_d.err = op_fail;
					s_d.dpoll = s_q.data[7];
				end
			S_EBAB:
				if (wr_stb && d8 == CMD_RESET)
				begin
					s_d.st = S_READ;
					s_d.abrt = 1'b0;
				end
			S_FAIL:
				if (wr_stb && d8 == CMD_RESET)
				begin
					s_d.st = S_READ;
					s_d.err = 1'b0;
				end
			default:
				s_d.st = S_READ;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= '{st: S_READ, default: '0};
		else
			s_q <= s_d;
	end

	// Outputs straight from the state register
	assign rdata = s_q.rdata;
	assign prog_stb = s_q.prog_stb;
	assign buf_stb = s_q.buf_stb;
	assign ers_sel_stb = s_q.sel_stb;
	assign ers_go_stb = s_q.go_stb;
	assign chip_ers_stb = s_q.chip_stb;
	assign op_addr = s_q.addr;
	assign op_data = s_q.data;
	assign ers_suspended = s_q.esusp;
	assign prog_suspended = (s_q.st == S_PSUSP);
	assign bypass_mode = s_q.byp;
	assign asel_mode = s_q.asel;
	assign ebp_mode = (s_q.st == S_EBP) || (s_q.st == S_EBLD) || (s_q.st == S_EBPG);
endmodule // flash_cmd_ctrl

// ===== flash_array_model.sv
// Array-side stand-in: data pattern, protection and suspended-block map
`timescale 1ns/100ps
module flash_array_model
#(
	parameter logic [7:0] PROT_BLK = 8'h07
)
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [23:0] addr,
	input wire logic [23:0] op_addr,
	input wire logic ers_sel_stb,
	input wire logic ers_suspended,
	input wire logic all_prot_req,
	input wire logic fail_req,
	output logic [15:0] array_rdata,
	output logic blk_prot,
	output logic blk_susp,
	output logic all_prot,
	output logic op_fail
);
	logic [255:0] sel_q;
	// Pattern tied to the address, so stale data is never taken for fresh
	assign array_rdata = {~addr[7:0], addr[7:0]};
	// One fixed protected block, or every block on request
	assign blk_prot = all_prot_req || addr[23:16] == PROT_BLK;
	assign all_prot = all_prot_req;
	assign op_fail = fail_req;
	// Blocks in the erase list count as suspended while erase is held
	assign blk_susp = ers_suspended && sel_q[addr[23:16]];
	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
			sel_q <= '0;
		else if (ers_sel_stb)
			sel_q[op_addr[23:16]] <= 1'b1;
endmodule // flash_array_model

// ===== flash_cmd_sva.sv
// Port-level assertions for the flash command controller
`timescale 1ns/100ps
module flash_cmd_sva
#(
	parameter int BLK_TMO_CYC = 500
)
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [23:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [15:0] rdata,
	input wire logic prog_stb,
	input wire logic [23:0] op_addr,
	input wire logic [15:0] op_data,
	input wire logic buf_stb,
	input wire logic ers_sel_stb,
	input wire logic ers_go_stb,
	input wire logic chip_ers_stb,
	input wire logic ers_suspended,
	input wire logic prog_suspended,
	input wire logic ebp_mode
);
	import flash_cmd_pkg::*;
	// Expiry is sampled one cycle after the timer's final count
	localparam logic [15:0] TMO_AT_GO = 16'(BLK_TMO_CYC + 1);
	logic [15:0] tmo_q;
	logic [15:0] tmo_d;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	// Cycles since the last block-select write, protected blocks included,
	// since those restart the window too; saturates so it never wraps
	always_comb
		tmo_d = (wr_stb && wdata[7:0] == CMD_BLK) ? 16'h0000
			: tmo_q + {15'h0000, tmo_q != 16'hFFFF};
	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
			tmo_q <= 16'h0000;
		else
			tmo_q <= tmo_d;
	// No program, buffer load, block select or erase suspend in the 8 cycles after a chip erase starts
	sequence quiet;
		!prog_stb && !buf_stb && !ers_sel_stb && !ers_suspended;
	endsequence
	sequence cmd(logic [7:0] c);
		$past(wr_stb) && $past(wdata[7:0]) == c;
	endsequence
	stb_cause_a: assert property (
		(prog_stb || buf_stb || ers_sel_stb || chip_ers_stb) |-> $past(wr_stb))
		else $error("operation strobe without a bus write");
	chip_code_a: assert property (chip_ers_stb |-> cmd(CMD_CHIP))
		else $error("chip erase started by a wrong code");
	blk_latch_a: assert property (ers_sel_stb |->
		cmd(CMD_BLK) ##0 (op_addr[23:16] == $past(addr[23:16])))
		else $error("block select does not match the written block");
	buf_word_a: assert property (buf_stb |->
		ebp_mode && op_addr == $past(addr) && op_data == $past(wdata))
		else $error("buffer word differs from the load write");
	ebp_enter_a: assert property ($rose(ebp_mode) |-> cmd(CMD_EBP_ENTER))
		else $error("enhanced mode entered without its code");
	go_tmo_a: assert property ((ers_go_stb && !$past(wr_stb)) |-> tmo_q == TMO_AT_GO)
		else $error("block erase started at the wrong time");
	ers_susp_a: assert property ($rose(ers_suspended) |-> cmd(CMD_SUSP))
		else $error("erase suspended without a suspend write");
	ers_resume_a: assert property ($fell(ers_suspended) |-> cmd(CMD_RESUME))
		else $error("erase left suspend without a resume write");
	prog_resume_a: assert property ($fell(prog_suspended) |-> cmd(CMD_RESUME))
		else $error("program left suspend without a resume write");
	quiet_chip_a: assert property (chip_ers_stb |=> quiet [*8])
		else $error("command accepted during chip erase");
	rdata_hold_a: assert property (!$past(rd_stb) |-> $stable(rdata))
		else $error("read data changed without a read");
endmodule // flash_cmd_sva

bind flash_cmd_ctrl flash_cmd_sva #(.BLK_TMO_CYC(BLK_TMO_CYC)) sva_chk
(
	.core_clk(core_clk),
	.resetn(resetn),
	.addr(addr),
	.wdata(wdata),
	.wr_stb(wr_stb),
	.rd_stb(rd_stb),
	.rdata(rdata),
	.prog_stb(prog_stb),
	.op_addr(op_addr),
	.op_data(op_data),
	.buf_stb(buf_stb),
	.ers_sel_stb(ers_sel_stb),
	.ers_go_stb(ers_go_stb),
	.chip_ers_stb(chip_ers_stb),
	.ers_suspended(ers_suspended),
	.prog_suspended(prog_suspended),
	.ebp_mode(ebp_mode)
);

// ===== tb_top.sv
// Self-checking bench for the flash command controller
`timescale 1ns/100ps
module tb_top;
	import flash_cmd_pkg::*;
	localparam int TMO = 20;
	localparam int ERS = 50;
	localparam int EBP = 40;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic [23:0] addr = '0;
	logic [15:0] wdata = '0;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic all_prot_req = 1'b0;
	logic fail_req = 1'b0;
	logic word_mode = 1'b1;
	logic [15:0] rdata, array_rdata, op_data, v;
	logic [23:0] op_addr;
	logic blk_prot, blk_susp, all_prot, op_fail, prog_stb, buf_stb, ers_sel_stb, ers_go_stb;
	logic chip_ers_stb, ers_suspended, prog_suspended, bypass_mode, asel_mode, ebp_mode;
	int bad_count = 0;
	int n_checks = 0;
	int n_prog = 0;
	int n_buf = 0;
	int n_sel = 0;
	int n_go = 0;
	int n_chip = 0;
	flash_cmd_ctrl #(.BLK_TMO_CYC(TMO), .ERASE_CYC(ERS), .EBP_CYC(EBP)) uut
	(
		.core_clk(core_clk),
		.resetn(resetn),
		.word_mode(word_mode),
		.addr(addr),
		.wdata(wdata),
		.wr_stb(wr_stb),
		.rd_stb(rd_stb),
		.rdata(rdata),
		.array_rdata(array_rdata),
		.blk_prot(blk_prot),
		.blk_susp(blk_susp),
		.all_prot(all_prot),
		.op_fail(op_fail),
		.prog_stb(prog_stb),
		.op_addr(op_addr),
		.op_data(op_data),
		.buf_stb(buf_stb),
		.ers_sel_stb(ers_sel_stb),
		.ers_go_stb(ers_go_stb),
		.chip_ers_stb(chip_ers_stb),
		.ers_suspended(ers_suspended),
		.prog_suspended(prog_suspended),
		.bypass_mode(bypass_mode),
		.asel_mode(asel_mode),
		.ebp_mode(ebp_mode)
	);
	flash_array_model arr
	(
		.core_clk(core_clk),
		.resetn(resetn),
		.addr(addr),
		.op_addr(op_addr),
		.ers_sel_stb(ers_sel_stb),
		.ers_suspended(ers_suspended),
		.all_prot_req(all_prot_req),
		.fail_req(fail_req),
		.array_rdata(array_rdata),
		.blk_prot(blk_prot),
		.blk_susp(blk_susp),
		.all_prot(all_prot),
		.op_fail(op_fail)
	);
	initial
		forever #50 core_clk = ~core_clk;
	// Pulses are tallied so scenarios compare counts, not single edges
	always @(posedge core_clk)
	begin
		n_prog += int'(prog_stb);
		n_buf += int'(buf_stb);
		n_sel += int'(ers_sel_stb);
		n_go += int'(ers_go_stb);
		n_chip += int'(chip_ers_stb);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// The #1 lets the edge's register updates land before any check
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [23:0] a, input logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= {8'h00, d};
		wr_stb <= 1'b1;
		@(posedge core_clk);
		wr_stb <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [23:0] a);
		@(posedge core_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge core_clk);
		rd_stb <= 1'b0;
		// Data stand in the cycle after the strobe; take them once settled
		#1;
		v = rdata;
	endtask
	task automatic unl;
		wr(24'h555, CMD_UNL1);
		wr(24'h2AA, CMD_UNL2);
	endtask
	task automatic t_chip(input logic ap, input logic fl, input int n);
		int c;
		logic [15:0] s;
		c = n_chip;
		all_prot_req <= ap;
		fail_req <= fl;
		unl;
		wr(24'h555, CMD_ERS_SETUP);
		unl;
		wr(24'h555, CMD_CHIP);
		wr(24'h0, CMD_SUSP);
		wr(24'h0, CMD_RESET);
		chk(n_chip - c, 1);
		rd(24'h0);
		s = v;
		rd(24'h0);
		chk((v ^ s) & 16'h0040, 16'h0040);
		chk(ers_suspended, 1'b0);
		idle(n);
		if (fl)
		begin
			rd(24'h12);
			chk(v & 16'h0020, 16'h0020);
			wr(24'h0, CMD_RESET);
		end
		fail_req <= 1'b0;
		all_prot_req <= 1'b0;
		rd(24'h12);
		chk(v, 16'hED12);
		$display("chip erase case done");
	endtask
	task automatic t_blk;
		int s;
		int p;
		s = n_sel;
		unl;
		wr(24'h555, CMD_ERS_SETUP);
		unl;
		wr(24'h030000, CMD_BLK);
		wr(24'h070000, CMD_BLK);
		wr(24'h050000, CMD_BLK);
		wr(24'h0, CMD_SUSP);
		chk(ers_suspended, 1'b1);
		chk(n_sel - s, 2);
		rd(24'h030000);
		chk(v & 16'hFF1D, 16'h0000);
		rd(24'h010044);
		chk(v, 16'hBB44);
		p = n_prog;
		unl;
		wr(24'h555, CMD_PROG);
		wr(24'h030010, 8'h12);
		unl;
		wr(24'h555, CMD_PROG);
		wr(24'h010010, 8'h12);
		idle(2);
		chk(n_prog - p, 1);
		chk(op_addr, 24'h010010);
		idle(170);
		unl;
		wr(24'h555, CMD_ASEL);
		chk(asel_mode, 1'b1);
		wr(24'h0, CMD_RESUME);
		chk(ers_suspended, 1'b1);
		wr(24'h0, CMD_RESET);
		wr(24'h0, CMD_RESUME);
		chk(ers_suspended, 1'b0);
		wr(24'h0, CMD_RESET);
		rd(24'h0);
		chk(v & 16'hFF1D, 16'h0000);
		idle(ERS + 5);
		rd(24'h0);
		chk(v, 16'hFF00);
		$display("block erase case done");
	endtask
	task automatic t_byp;
		int s;
		int c;
		int g;
		c = n_chip;
		g = n_go;
		unl;
		wr(24'h555, CMD_BYP);
		chk(bypass_mode, 1'b1);
		// Reset inside the selection window drops the erase before it starts
		wr(24'h0, CMD_ERS_SETUP);
		wr(24'h0B0000, CMD_BLK);
		wr(24'h0, CMD_RESET);
		idle(TMO + 5);
		rd(24'h0);
		chk(v, 16'hFF00);
		chk(n_go - g, 0);
		s = n_sel;
		wr(24'h0, CMD_ERS_SETUP);
		wr(24'h020000, CMD_BLK);
		wr(24'h080000, CMD_BLK);
		idle(TMO + ERS + 5);
		chk(n_sel - s, 2);
		chk(n_go - g, 1);
		wr(24'h0, CMD_ERS_SETUP);
		wr(24'h0, CMD_CHIP);
		idle(ERS + 5);
		chk(n_chip - c, 1);
		wr(24'h0, CMD_EXIT1);
		wr(24'h0, CMD_EXIT2);
		chk(bypass_mode, 1'b0);
		$display("bypass erase case done");
	endtask
	task automatic t_prog;
		int p;
		p = n_prog;
		unl;
		wr(24'h555, CMD_PROG);
		wr(24'h040000, 8'h5A);
		wr(24'h0, CMD_SUSP);
		chk(prog_suspended, 1'b1);
		wr(24'h0, CMD_RESUME);
		chk(prog_suspended, 1'b0);
		wr(24'h0, CMD_RESUME);
		wr(24'h0, CMD_SUSP);
		chk(prog_suspended, 1'b1);
		wr(24'h0, CMD_RESUME);
		idle(170);
		rd(24'h12);
		chk(v, 16'hED12);
		chk(n_prog - p, 1);
		chk(op_data, 16'h005A);
		$display("program suspend case done");
	endtask
	task automatic t_ebp;
		int b;
		logic [15:0] s;
		// Byte-wide bus: the enter code after a good x8 unlock is refused
		word_mode <= 1'b0;
		idle(3);
		wr(24'hAAA, CMD_UNL1);
		wr(24'h555, CMD_UNL2);
		wr(24'hAAA, CMD_EBP_ENTER);
		chk(ebp_mode, 1'b0);
		word_mode <= 1'b1;
		idle(3);
		b = n_buf;
		unl;
		wr(24'h555, CMD_EBP_ENTER);
		chk(ebp_mode, 1'b1);
		wr(24'h060000, CMD_EBP_SETUP);
		for (int i = 0; i < EBP_WORDS; i++)
			wr({16'h0600, 8'(i)}, 8'(i));
		wr(24'h060000, CMD_CONFIRM);
		chk(n_buf - b, EBP_WORDS);
		idle(EBP + 5);
		chk(ebp_mode, 1'b1);
		wr(24'h0, CMD_EXIT1);
		wr(24'h0, CMD_EXIT2);
		chk(ebp_mode, 1'b0);
		unl;
		wr(24'h555, CMD_EBP_ENTER);
		wr(24'h060000, CMD_EBP_SETUP);
		wr(24'h060000, 8'h01);
		wr(24'h060002, 8'h02);
		rd(24'h0);
		s = v;
		rd(24'h0);
		chk(v & 16'h0022, 16'h0002);
		chk((v ^ s) & 16'h0040, 16'h0040);
		wr(24'h0, CMD_RESET);
		rd(24'h12);
		chk(v, 16'hED12);
		$display("enhanced buffer case done");
	endtask
	task automatic test_done;
		$display("checks=%0d mismatches=%0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		idle(6);
		t_chip(1'b0, 1'b1, ERS + 5);
		t_chip(1'b1, 1'b0, PROT_CYC + 5);
		t_blk;
		t_byp;
		t_prog;
		t_ebp;
		test_done;
	end
	// Whole run needs about 2400 cycles; a hang is cut off well past that
	initial
	begin
		repeat (10000) @(posedge core_clk);
		bad_count++;
		test_done;
	end
endmodule // tb_top
